// File: common/eeprom_defines.svh
`ifndef EEPROM_DEFINES_SVH
`define EEPROM_DEFINES_SVH

`define CLK_PERIOD_NS 50
`define CLK_MHZ 20
`define WRITE_TIME_US 5000
`define SCL_PERIOD_NS 2000
`define TIMER_W 24

`define TYPE_MEM 4'hA
`define TYPE_ID 4'hB
`define PAGE_BITS 7
`define ID_LOCK_BIT 10
`define LOCK_DATA_BIT 1
`define BITS_PER_BYTE 4'h8
`define LAST_TX_BIT 4'h7
`define IDX_DATA 2'h3

`define REG_CMD 3'h0
`define REG_DEV 3'h1
`define REG_MADDR 3'h2
`define REG_WDATA 3'h3
`define REG_STATUS 3'h4
`define ST_NACK_BIT 8
`define ST_BUSY_BIT 9

`endif

// File: common/eeprom_pkg.sv
`include "eeprom_defines.svh"

package eeprom_pkg;

  typedef enum logic [2:0] {
    DS_IDLE, DS_RX, DS_ACK, DS_TX, DS_MACK
  } dev_state_type;

  typedef struct packed {
    dev_state_type st;
    logic [3:0] bitcnt;
    logic [7:0] sh;
    logic sda_oe;
    logic [15:0] addr;
    logic [1:0] idx;
    logic rw;
    logic is_id;
    logic wrote;
    logic id_locked;
    logic busy;
    logic [`TIMER_W-1:0] timer;
  } dev_reg_type;

  typedef enum logic [1:0] {OP_NONE, OP_WRITE, OP_READ, OP_POLL} op_type;
  typedef enum logic [1:0] {K_START, K_TX, K_RX, K_STOP} kind_type;
  typedef enum logic {MS_IDLE, MS_RUN} mst_state_type;

  typedef struct packed {
    mst_state_type st;
    op_type op;
    logic [2:0] step;
    logic [1:0] phase;
    logic [7:0] qcnt;
    logic [3:0] bitcnt;
    logic [7:0] sh;
    logic scl_oe;
    logic sda_oe;
    logic [6:0] dev;
    logic [15:0] maddr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic nack;
    logic [15:0] rdq;
  } mst_reg_type;

endpackage

// File: common/two_wire_if.sv
`timescale 1ns/1ns

interface two_wire_if;
  logic scl_o_m;
  logic scl_oe_m;
  logic sda_o_m;
  logic sda_oe_m;
  logic sda_o_d;
  logic sda_oe_d;
  logic scl;
  logic sda;

  // Pull-up gives the high level; any enabled low driver wins
  assign scl = !(scl_oe_m && !scl_o_m);
  assign sda = !((sda_oe_m && !sda_o_m) || (sda_oe_d && !sda_o_d));

  modport dev (
    input scl,
    input sda,
    output sda_o_d,
    output sda_oe_d
  );

  modport mst (
    input scl,
    input sda,
    output scl_o_m,
    output scl_oe_m,
    output sda_o_m,
    output sda_oe_m
  );
endinterface

// File: rtl/line_sampler.sv
`timescale 1ns/1ns

module line_sampler #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] din,
  output logic [W-1:0] sync,
  output logic [W-1:0] prev
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q <= INIT;
      sync_q <= INIT;
      prev_q <= INIT;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign sync = sync_q;
  assign prev = prev_q;
endmodule

// File: rtl/eeprom_slave.sv
`timescale 1ns/1ns
`include "eeprom_defines.svh"

module eeprom_slave
  import eeprom_pkg::*;
#(
  parameter int DEPTH = 65536,
  parameter int PAGE = 128,
  parameter int WRITE_CYCLES = `WRITE_TIME_US * `CLK_MHZ
) (
  input wire logic clk,
  input wire logic reset,
  two_wire_if.dev bus,
  input wire logic hw_addr_bit0_pin,
  input wire logic hw_addr_bit1_pin,
  input wire logic hw_addr_bit2_pin,
  input wire logic write_protect_pin,
  output logic write_busy,
  output logic standby
);
  dev_reg_type s_q;
  dev_reg_type s_d;

  logic [7:0] mem [DEPTH];
  logic [7:0] id_mem [PAGE];

  logic scl;
  logic sda;
  logic scl_p;
  logic sda_p;
  logic [3:0] pins;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic mem_we;
  logic id_we;
  logic ack;
  logic load_tx;
  logic wp;
  logic [2:0] hw_addr;
  logic [7:0] rdata;

  // Bus lines resync and remember last sample
  line_sampler #(.W(2), .INIT(2'h3)) line_sync (
    .clk(clk),
    .reset(reset),
    .din({bus.scl, bus.sda}),
    .sync({scl, sda}),
    .prev({scl_p, sda_p})
  );

  // Straps resynced too; bench ties open pins low
  line_sampler #(.W(4), .INIT(4'h0)) strap_sync (
    .clk(clk),
    .reset(reset),
    .din({write_protect_pin, hw_addr_bit2_pin,
          hw_addr_bit1_pin, hw_addr_bit0_pin}),
    .sync(pins),
    .prev()
  );

  assign wp = pins[3];
  assign hw_addr = pins[2:0];

  // Conditions come from registered copies only
  assign rise = scl && !scl_p;
  assign fall = !scl && scl_p;
  assign start = scl && scl_p && sda_p && !sda;
  assign stop = scl && scl_p && !sda_p && sda;

  assign rdata = s_q.is_id ? id_mem[s_q.addr[`PAGE_BITS-1:0]]
                           : mem[s_q.addr];

  always_comb begin
    s_d = s_q;
    mem_we = 1'b0;
    id_we = 1'b0;
    ack = 1'b0;
    load_tx = 1'b0;

    // Write cycle runs on its own and clears itself
    if (s_q.busy) begin
      if (s_q.timer == '0) begin
        s_d.busy = 1'b0;
      end else begin
        s_d.timer = s_q.timer - 1'b1;
      end
    end

    case (s_q.st)
      DS_IDLE: begin
        s_d.sda_oe = 1'b0;
      end
      DS_RX: begin
        if (rise) begin
          s_d.sh = {s_q.sh[6:0], sda};
          s_d.bitcnt = s_q.bitcnt + 1'b1;
        end else if (fall && s_q.bitcnt == `BITS_PER_BYTE) begin
          case (s_q.idx)
            2'h0: begin
              // Busy part stays silent so the master can poll
              if ((s_q.sh[7:4] == `TYPE_MEM || s_q.sh[7:4] == `TYPE_ID)
                  && s_q.sh[3:1] == hw_addr && !s_q.busy) begin
                ack = 1'b1;
                s_d.rw = s_q.sh[0];
                s_d.is_id = (s_q.sh[7:4] == `TYPE_ID);
              end
            end
            2'h1: begin
              s_d.addr[15:8] = s_q.sh;
              ack = 1'b1;
            end
            2'h2: begin
              s_d.addr[7:0] = s_q.sh;
              ack = 1'b1;
            end
            default: begin
              if (s_q.is_id && s_q.addr[`ID_LOCK_BIT]) begin
                ack = !s_q.id_locked;
                if (!s_q.id_locked && !wp && s_q.sh[`LOCK_DATA_BIT]) begin
                  s_d.id_locked = 1'b1;
                  s_d.wrote = 1'b1;
                end
              end else if (s_q.is_id) begin
                ack = !s_q.id_locked;
                id_we = !s_q.id_locked && !wp;
              end else begin
                ack = 1'b1;
                mem_we = !wp;
              end
              if (mem_we || id_we) begin
                s_d.wrote = 1'b1;
              end
              // Stays inside the page, so extra bytes overwrite
              s_d.addr[`PAGE_BITS-1:0] =
                s_q.addr[`PAGE_BITS-1:0] + 1'b1;
            end
          endcase
          if (s_q.idx != `IDX_DATA) begin
            s_d.idx = s_q.idx + 1'b1;
          end
          s_d.bitcnt = '0;
          s_d.sda_oe = ack;
          s_d.st = ack ? DS_ACK : DS_IDLE;
        end
      end
      DS_ACK: begin
        if (fall) begin
          s_d.sda_oe = 1'b0;
          s_d.bitcnt = '0;
          if (s_q.rw) begin
            load_tx = 1'b1;
          end else begin
            s_d.st = DS_RX;
          end
        end
      end
      DS_TX: begin
        if (fall) begin
          if (s_q.bitcnt == `LAST_TX_BIT) begin
            s_d.sda_oe = 1'b0;
            s_d.bitcnt = '0;
            s_d.st = DS_MACK;
          end else begin
            s_d.sh = {s_q.sh[6:0], 1'b0};
            s_d.sda_oe = !s_q.sh[6];
            s_d.bitcnt = s_q.bitcnt + 1'b1;
          end
        end
      end
      DS_MACK: begin
        // Master's no-acknowledge ends the read
        if (rise) begin
          if (sda) begin
            s_d.st = DS_IDLE;
          end else begin
            s_d.bitcnt = `BITS_PER_BYTE;
          end
        end else if (fall && s_q.bitcnt == `BITS_PER_BYTE) begin
          load_tx = 1'b1;
        end
      end
      default: begin
        s_d.st = DS_IDLE;
      end
    endcase

    if (load_tx) begin
      s_d.st = DS_TX;
      s_d.sh = rdata;
      s_d.bitcnt = '0;
      s_d.sda_oe = !rdata[7];
      s_d.addr = s_q.addr + 1'b1;
    end

    // Stop hands over to the write cycle when a byte or the lock was stored (not while write protected)
    if (stop) begin
      s_d.st = DS_IDLE;
      s_d.sda_oe = 1'b0;
      if (s_q.wrote) begin
        s_d.busy = 1'b1;
        s_d.timer = `TIMER_W'(WRITE_CYCLES - 1);
        s_d.wrote = 1'b0;
      end
    end

    // Any start drops whatever the bus logic was doing
    if (start) begin
      s_d.st = DS_RX;
      s_d.bitcnt = '0;
      s_d.idx = '0;
      s_d.sda_oe = 1'b0;
      s_d.wrote = 1'b0;
    end
  end

  // Power-on reset doubles as the synchronous reset
  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Bytes land at once; the timer hides this from the bus
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[s_q.addr] <= s_q.sh;
    end
    if (id_we) begin
      id_mem[s_q.addr[`PAGE_BITS-1:0]] <= s_q.sh;
    end
  end

  assign bus.sda_o_d = 1'b0;
  assign bus.sda_oe_d = s_q.sda_oe;
  assign write_busy = s_q.busy;
  assign standby = (s_q.st == DS_IDLE) && !s_q.busy;
endmodule

// File: rtl/two_wire_master.sv
`timescale 1ns/1ns
`include "eeprom_defines.svh"

module two_wire_master
  import eeprom_pkg::*;
#(
  parameter int QUARTER =
    (`SCL_PERIOD_NS / 4 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic reset,
  two_wire_if.mst bus,
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata
);
  mst_reg_type s_q;
  mst_reg_type s_d;
  logic sda;
  kind_type kind;
  logic [1:0] drv;

  line_sampler #(.W(1), .INIT(1'h1)) sda_sync (
    .clk(clk),
    .reset(reset),
    .din(bus.sda),
    .sync(sda),
    .prev()
  );

  // Step sequence per operation; past the end means stop
  function automatic kind_type step_kind(op_type op, logic [2:0] i);
    case (op)
      OP_WRITE: step_kind = (i == 3'h0) ? K_START
                          : (i < 3'h5) ? K_TX : K_STOP;
      OP_READ: step_kind = (i == 3'h0 || i == 3'h4) ? K_START
                         : (i == 3'h6) ? K_RX
                         : (i == 3'h7) ? K_STOP : K_TX;
      // Poll opens with a start like every other transfer
      default: step_kind = (i == 3'h0) ? K_START
                         : (i == 3'h1) ? K_TX : K_STOP;
    endcase
  endfunction

  function automatic logic [2:0] last_step(op_type op);
    case (op)
      OP_WRITE: last_step = 3'h5;
      OP_READ: last_step = 3'h7;
      default: last_step = 3'h2;
    endcase
  endfunction

  // Slave id first, then address, then data
  function automatic logic [7:0] step_byte(mst_reg_type r,
                                           logic [2:0] i);
    case (i)
      3'h1: step_byte = {r.dev, 1'b0};
      3'h2: step_byte = r.maddr[15:8];
      3'h3: step_byte = r.maddr[7:0];
      3'h4: step_byte = r.wdata;
      default: step_byte = {r.dev, 1'b1};
    endcase
  endfunction

  // Returns {scl low, sda low} for a phase
  function automatic logic [1:0] drive(kind_type k, logic [1:0] p,
                                       logic low);
    case (k)
      K_START: drive = {p == 2'h0 || p == 2'h3, p[1]};
      K_STOP: drive = {p == 2'h0, !p[1]};
      default: drive = {p == 2'h0 || p == 2'h3, low};
    endcase
  endfunction

  assign kind = step_kind(s_q.op, s_q.step);

  always_comb begin
    s_d = s_q;
    drv = 2'h0;
    if (s_q.st == MS_RUN) begin
      if (s_q.qcnt != '0) begin
        s_d.qcnt = s_q.qcnt - 1'b1;
      end else begin
        s_d.qcnt = 8'(QUARTER - 1);
        s_d.phase = s_q.phase + 1'b1;
        if (s_q.phase == 2'h2 && kind != K_START && kind != K_STOP) begin
          if (s_q.bitcnt == `BITS_PER_BYTE) begin
            if (kind == K_TX) begin
              s_d.nack = sda;
            end
          end else if (kind == K_RX) begin
            s_d.sh = {s_q.sh[6:0], sda};
          end
        end
        if (s_q.phase == 2'h3) begin
          if ((kind == K_TX || kind == K_RX)
              && s_q.bitcnt != `BITS_PER_BYTE) begin
            s_d.bitcnt = s_q.bitcnt + 1'b1;
            if (kind == K_TX) begin
              s_d.sh = {s_q.sh[6:0], 1'b1};
            end
          end else if (kind == K_STOP) begin
            s_d.st = MS_IDLE;
          end else begin
            s_d.bitcnt = '0;
            if (kind == K_RX) begin
              s_d.rdata = s_q.sh;
            end
            // No acknowledge cuts straight to the stop
            if (kind == K_TX && s_d.nack) begin
              s_d.step = last_step(s_q.op);
            end else begin
              s_d.step = s_q.step + 1'b1;
            end
            s_d.sh = step_byte(s_q, s_d.step);
          end
        end
        drv = drive(step_kind(s_d.op, s_d.step), s_d.phase,
                    step_kind(s_d.op, s_d.step) == K_TX
                    && s_d.bitcnt != `BITS_PER_BYTE && !s_d.sh[7]);
        s_d.scl_oe = drv[1];
        s_d.sda_oe = drv[0];
      end
    end

    if (reg_wr) begin
      case (reg_addr)
        `REG_CMD: begin
          // Command while a transfer runs is dropped
          if (s_q.st == MS_IDLE && reg_wdata[1:0] != 2'h0) begin
            s_d.st = MS_RUN;
            s_d.op = op_type'(reg_wdata[1:0]);
            s_d.step = '0;
            s_d.phase = '0;
            s_d.bitcnt = '0;
            s_d.nack = 1'b0;
            s_d.qcnt = 8'(QUARTER - 1);
            s_d.scl_oe = 1'b1;
            s_d.sda_oe = 1'b0;
          end
        end
        `REG_DEV: s_d.dev = reg_wdata[6:0];
        `REG_MADDR: s_d.maddr = reg_wdata;
        `REG_WDATA: s_d.wdata = reg_wdata[7:0];
        default: s_d.dev = s_q.dev;
      endcase
    end

    s_d.rdq = '0;
    if (reg_rd) begin
      case (reg_addr)
        `REG_DEV: s_d.rdq = {9'h000, s_q.dev};
        `REG_MADDR: s_d.rdq = s_q.maddr;
        `REG_WDATA: s_d.rdq = {8'h00, s_q.wdata};
        `REG_STATUS: begin
          s_d.rdq = {8'h00, s_q.rdata};
          s_d.rdq[`ST_NACK_BIT] = s_q.nack;
          s_d.rdq[`ST_BUSY_BIT] = (s_q.st == MS_RUN);
        end
        default: s_d.rdq = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.scl_o_m = 1'b0;
  assign bus.scl_oe_m = s_q.scl_oe;
  assign bus.sda_o_m = 1'b0;
  assign bus.sda_oe_m = s_q.sda_oe;
  assign reg_rdata = s_q.rdq;
endmodule

// File: verification/eeprom_link_chk.sv
`timescale 1ns/1ns

module eeprom_link_chk #(
  parameter int WRITE_CYCLES = 400
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_o_d,
  input wire logic sda_oe_d,
  input wire logic write_busy,
  input wire logic standby
);
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;

  // Counts busy cycles; cleared whenever the write cycle is idle
  always_comb begin
    cnt_d = write_busy ? cnt_q + 16'h0001 : 16'h0000;
  end

  always_ff @(posedge clk) begin
    cnt_q <= cnt_d;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence s_start;
    scl && $past(scl) && $fell(sda);
  endsequence

  sequence s_stop;
    scl && $past(scl) && $rose(sda);
  endsequence

  a_open_drain: assert property (sda_o_d == 1'b0)
    else $error("device drives data line high");
  a_drive_low: assert property (sda_oe_d |-> !sda)
    else $error("data line high while device pulls it");
  a_reset_idle: assert property ($past(reset) |->
    !sda_oe_d && standby && !write_busy)
    else $error("device not in standby after reset");
  a_change_low: assert property ($changed(sda_oe_d) |-> !scl)
    else $error("device changed data with clock high");
  a_ack_hold: assert property ($rose(sda_oe_d) |-> sda_oe_d[*8])
    else $error("device pulse on data line too short");
  a_quiet_start: assert property (s_start |=> !sda_oe_d[*8])
    else $error("device drives data right after start");
  a_busy_nack: assert property (write_busy |-> !sda_oe_d)
    else $error("device answered during write cycle");
  a_busy_time: assert property ($fell(write_busy) |->
    cnt_q >= WRITE_CYCLES - 1 && cnt_q <= WRITE_CYCLES + 1)
    else $error("write cycle length wrong");
  a_stop_rest: assert property (s_stop |->
    ##[1:8] (standby || write_busy))
    else $error("no standby or write cycle after stop");
  a_busy_standby: assert property (write_busy |-> !standby)
    else $error("standby during write cycle");
endmodule

// File: verification/test_two_wire_eeprom_slave_interface.sv
`timescale 1ns/1ns

module test_two_wire_eeprom_slave_interface;
  import eeprom_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic [2:0] pins = 3'h0;
  logic wp = 1'b0;
  logic write_busy;
  logic standby;
  logic [31:0] rng = 32'h0000F6C4;
  int bad_count = 0;
  int tests_run = 0;
  int cyc = 0;

  two_wire_if bus ();

  // Short write cycle, still longer than an address phase so polls see it
  eeprom_slave #(.WRITE_CYCLES(400)) i_eeprom_slave (
    .clk(clk),
    .reset(reset),
    .bus(bus),
    .hw_addr_bit0_pin(pins[0]),
    .hw_addr_bit1_pin(pins[1]),
    .hw_addr_bit2_pin(pins[2]),
    .write_protect_pin(wp),
    .write_busy(write_busy),
    .standby(standby)
  );

  two_wire_master #(.QUARTER(5)) i_two_wire_master (
    .clk(clk),
    .reset(reset),
    .bus(bus),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata)
  );

  eeprom_link_chk #(.WRITE_CYCLES(400)) i_eeprom_link_chk (
    .clk(clk),
    .reset(reset),
    .scl(bus.scl),
    .sda(bus.sda),
    .sda_o_d(bus.sda_o_d),
    .sda_oe_d(bus.sda_oe_d),
    .write_busy(write_busy),
    .standby(standby)
  );

  always #25 clk = ~clk;

  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  // Expected no-acknowledge bit for an address byte against the straps
  function automatic logic [15:0] exp_nack(input logic [6:0] dev,
      input logic [2:0] strap);
    return {15'h0000, !(dev[6:4] == 3'h5 && dev[2:0] == strap)};
  endfunction

  task automatic wrap_up();
    if (bad_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      bad_count = bad_count + 1;
      wrap_up();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // Polls until the master is done; the global cycle limit catches a hang
  task automatic run(input logic [1:0] op, input logic [6:0] dev,
      input logic [15:0] ma, input logic [7:0] wd,
      output logic [15:0] st);
    wr(3'h1, {9'h000, dev});
    wr(3'h2, ma);
    wr(3'h3, {8'h00, wd});
    wr(3'h0, {14'h0000, op});
    st = 16'h0200;
    while (st[9] !== 1'b0) begin
      rd(3'h4, st);
    end
  endtask

  task automatic settle();
    repeat (600) if (write_busy !== 1'b0) @(posedge clk);
  endtask

  initial begin
    logic [15:0] st;
    logic [15:0] ad;
    logic [31:0] r;
    logic [7:0] d;
    logic [2:0] p;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    check({15'h0000, standby}, 16'h0001);
    check({15'h0000, write_busy}, 16'h0000);
    rd(3'h4, st);
    check(st, 16'h0000);
    rd(3'h7, st);
    check(st, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      r = xs();
      p = r[2:0];
      pins <= p;
      ad = (i == 0) ? 16'hFFFF : r[31:16];
      d = r[10:3];
      run(2'h1, {4'hA, p}, ad, d, st);
      check({15'h0000, st[8]}, exp_nack({4'hA, p}, p));
      run(2'h3, {4'hA, p}, 16'h0000, 8'h00, st);
      check({15'h0000, st[8]}, 16'h0001);
      settle();
      run(2'h3, {4'hA, p}, 16'h0000, 8'h00, st);
      check({15'h0000, st[8]}, 16'h0000);
      run(2'h2, {4'hA, p}, ad, 8'h00, st);
      check({8'h00, st[7:0]}, {8'h00, d});
      run(2'h1, {4'hA, p ^ 3'h1}, ad, d, st);
      check({15'h0000, st[8]}, exp_nack({4'hA, p ^ 3'h1}, p));
    end
    wp <= 1'b1;
    run(2'h1, {4'hA, p}, ad, ~d, st);
    check({15'h0000, st[8]}, 16'h0000);
    repeat (10) @(posedge clk);
    check({15'h0000, write_busy}, 16'h0000);
    run(2'h2, {4'hA, p}, ad, 8'h00, st);
    check({8'h00, st[7:0]}, {8'h00, d});
    wp <= 1'b0;
    run(2'h1, {4'hB, p}, 16'h0012, 8'h3C, st);
    check({15'h0000, st[8]}, 16'h0000);
    settle();
    run(2'h1, {4'hB, p}, 16'h0400, 8'h02, st);
    check({15'h0000, st[8]}, 16'h0000);
    settle();
    run(2'h1, {4'hB, p}, 16'h0012, 8'hC3, st);
    check({15'h0000, st[8]}, 16'h0001);
    run(2'h2, {4'hB, p}, 16'h0012, 8'h00, st);
    check({8'h00, st[7:0]}, 16'h003C);
    // Power loss in mid write cycle
    run(2'h1, {4'hA, p}, ad, 8'h77, st);
    repeat (20) if (write_busy !== 1'b1) @(posedge clk);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    check({15'h0000, write_busy}, 16'h0000);
    check({15'h0000, standby}, 16'h0001);
    run(2'h3, {4'hA, p}, 16'h0000, 8'h00, st);
    check({15'h0000, st[8]}, 16'h0000);
    wrap_up();
  end
endmodule
